// file: core/pwm_event_fault_output_ctrl.sv
// PWM module control: event enables, status, fault suppression, polarity
`timescale 1ns/1ns

//
// Contract
// - Clearing a generator enable bit masks that source; other bits keep.
// - Setting a generator enable bit lets that event reach its output.
// - Six events per generator, each with interrupt and trigger enable.
// - Period is the tick count between successive zero event pulses, one less for an odd period in up-down mode.
// - Period readback gives the last programmed value, maybe not active.
// - A new period write overwrites any still pending value.
// - Module enable holds four generator and four fault bits; set unmasks.
// - Clearing a module enable bit masks only that interrupt.
// - Raw and masked module status, masked being raw AND enables.
// - Module status: four generator summaries and four faults, eight bits.
// - Suppressed outputs go inactive while a fault is active.
// - Non-suppressed outputs keep their waveform during a fault.
// - Flip set drives the inverse waveform, making the output active low.
// - Flip clear passes the waveform unchanged, active high.
// - Generator status bits clear on writing one; zero leaves them.
// - Pending period and width updates apply only at counter zero.
module pwm_event_fault_output_ctrl #(
  parameter int G  = pwm_ctrl_pkg::NUM_GEN,
  parameter int W  = pwm_ctrl_pkg::PERIOD_W
) (
  input  wire logic                                   clk_sys_in,
  input  wire logic                                   rst_b_in,
  // Generator counters
  input  wire logic [G-1:0]                           gen_run_in,
  input  wire logic [G-1:0]                           gen_up_down_in,
  input  wire logic [G-1:0]                           period_wr_in,
  input  wire logic [W-1:0]                           period_wdata_in,
  input  wire logic [G-1:0]                           cmp_a_wr_in,
  input  wire logic [G-1:0]                           cmp_b_wr_in,
  input  wire logic [W-1:0]                           cmp_wdata_in,
  output logic      [G-1:0][W-1:0]                    period_rd_out,
  // Generator interrupt and trigger enables, set and clear masks
  input  wire logic [G-1:0][pwm_ctrl_pkg::IT_W-1:0]   inttrig_set_in,
  input  wire logic [G-1:0][pwm_ctrl_pkg::IT_W-1:0]   inttrig_clr_in,
  output logic      [G-1:0][pwm_ctrl_pkg::IT_W-1:0]   inttrig_en_out,
  // Generator status, write one to clear, and trigger pulses
  input  wire logic [G-1:0][pwm_ctrl_pkg::NUM_EV-1:0] gen_status_clr_in,
  output logic      [G-1:0][pwm_ctrl_pkg::NUM_EV-1:0] gen_status_out,
  output logic      [G-1:0][pwm_ctrl_pkg::NUM_EV-1:0] gen_trig_out,
  // Module interrupt enables and status
  input  wire logic [pwm_ctrl_pkg::MOD_W-1:0]         mod_en_set_in,
  input  wire logic [pwm_ctrl_pkg::MOD_W-1:0]         mod_en_clr_in,
  output logic      [pwm_ctrl_pkg::MOD_W-1:0]         mod_en_out,
  input  wire logic [pwm_ctrl_pkg::NUM_FAULT-1:0]     fault_irq_clr_in,
  input  wire logic                                   select_masked_view_in,
  output logic      [pwm_ctrl_pkg::MOD_W-1:0]         mod_status_out,
  // Faults and output shaping
  input  wire logic [pwm_ctrl_pkg::NUM_FAULT-1:0]     fault_in,
  input  wire logic                                   suppress_wr_in,
  input  wire logic                                   flip_wr_in,
  input  wire logic [pwm_ctrl_pkg::NUM_OUT-1:0]       out_sel_in,
  input  wire logic                                   cfg_value_in,
  output logic      [pwm_ctrl_pkg::NUM_OUT-1:0]       suppress_on_fault_out,
  output logic      [pwm_ctrl_pkg::NUM_OUT-1:0]       output_polarity_flip_out,
  output logic      [pwm_ctrl_pkg::NUM_OUT-1:0]       pwm_out
);

  // ----------------------------------------------------------------------
  // Per generator state
  // ----------------------------------------------------------------------
  pwm_ctrl_pkg::gen_events_t               ev      [G];
  logic [G-1:0]                            wave_a;
  logic [G-1:0]                            wave_b;
  logic [G-1:0][W-1:0]                     period_prog;
  logic [G-1:0][pwm_ctrl_pkg::IT_W-1:0]    it_en_q;
  logic [G-1:0][pwm_ctrl_pkg::NUM_EV-1:0]  gen_raw_q;
  logic [G-1:0][pwm_ctrl_pkg::NUM_EV-1:0]  gen_masked;
  logic [G-1:0]                            gen_summary;

  for (genvar g = 0; g < G; g++) begin : g_gen
    logic [pwm_ctrl_pkg::NUM_EV-1:0] irq_en;
    logic [pwm_ctrl_pkg::NUM_EV-1:0] trig_en;
    logic [pwm_ctrl_pkg::NUM_EV-1:0] ev_bits;

    pwm_gen_unit #(
      .W (W)
    ) u_gen (
      .clk_sys_in      (clk_sys_in),
      .rst_b_in        (rst_b_in),
      .run_in          (gen_run_in[g]),
      .up_down_in      (gen_up_down_in[g]),
      .period_wr_in    (period_wr_in[g]),
      .period_in       (period_wdata_in),
      .cmp_a_wr_in     (cmp_a_wr_in[g]),
      .cmp_a_in        (cmp_wdata_in),
      .cmp_b_wr_in     (cmp_b_wr_in[g]),
      .cmp_b_in        (cmp_wdata_in),
      .period_prog_out (period_prog[g]),
      .events_out      (ev[g]),
      .wave_a_out      (wave_a[g]),
      .wave_b_out      (wave_b[g])
    );

    // Six events, each with its own interrupt and trigger enable
    assign ev_bits = ev[g];
    assign irq_en  = it_en_q[g][pwm_ctrl_pkg::IRQ_LSB +:
                                pwm_ctrl_pkg::NUM_EV];
    assign trig_en = it_en_q[g][pwm_ctrl_pkg::TRIG_LSB +:
                                pwm_ctrl_pkg::NUM_EV];

    // Set and clear only touch the bits named; set wins a tie
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        it_en_q[g] <= pwm_ctrl_pkg::IT_EN_RST;
      end else begin
        it_en_q[g] <= (it_en_q[g] & ~inttrig_clr_in[g])
                      | inttrig_set_in[g];
      end
    end

    // Sticky raw status; a new event beats a clear in the same cycle
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        gen_raw_q[g] <= '0;
      end else begin
        gen_raw_q[g] <= (gen_raw_q[g] & ~gen_status_clr_in[g])
                        | ev_bits;
      end
    end

    // Masked source reaches the summary interrupt only when enabled
    assign gen_masked[g]  = gen_raw_q[g] & irq_en;
    assign gen_summary[g] = |gen_masked[g];

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        gen_trig_out[g]   <= '0;
        gen_status_out[g] <= '0;
        period_rd_out[g]  <= pwm_ctrl_pkg::PERIOD_RST;
      end else begin
        gen_trig_out[g]   <= ev_bits & trig_en;
        gen_status_out[g] <= select_masked_view_in ? gen_masked[g] :
                             gen_raw_q[g];
        period_rd_out[g]  <= period_prog[g];
      end
    end
  end

  assign inttrig_en_out = it_en_q;

  // ----------------------------------------------------------------------
  // Module interrupt enables and status
  // ----------------------------------------------------------------------
  logic [pwm_ctrl_pkg::MOD_W-1:0]     mod_en_q;
  logic [pwm_ctrl_pkg::NUM_FAULT-1:0] fault_raw_q;
  logic [pwm_ctrl_pkg::MOD_W-1:0]     mod_raw;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mod_en_q <= pwm_ctrl_pkg::MOD_EN_RST;
    end else begin
      mod_en_q <= (mod_en_q & ~mod_en_clr_in)
                  | mod_en_set_in;
    end
  end

  // Fault interrupt latches while any fault level is seen
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fault_raw_q <= '0;
    end else begin
      fault_raw_q <= (fault_raw_q & ~fault_irq_clr_in) | fault_in;
    end
  end

  // Generator summaries low, faults high, one eight-bit field
  always_comb begin
    mod_raw = '0;
    mod_raw[pwm_ctrl_pkg::MOD_GEN_LSB +: G] = gen_summary;
    mod_raw[pwm_ctrl_pkg::MOD_FLT_LSB +:
            pwm_ctrl_pkg::NUM_FAULT] = fault_raw_q;
  end

  // Status is registered, so it trails the event by two cycles, one after the raw latch
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mod_status_out <= '0;
      mod_en_out     <= pwm_ctrl_pkg::MOD_EN_RST;
    end else begin
      mod_status_out <= select_masked_view_in ? (mod_raw & mod_en_q)
                        : mod_raw;
      mod_en_out     <= mod_en_q;
    end
  end

  // ----------------------------------------------------------------------
  // Fault suppression and polarity
  // ----------------------------------------------------------------------
  logic [pwm_ctrl_pkg::NUM_OUT-1:0] suppress_q;
  logic [pwm_ctrl_pkg::NUM_OUT-1:0] flip_q;
  logic [pwm_ctrl_pkg::NUM_OUT-1:0] wave;
  logic [pwm_ctrl_pkg::NUM_OUT-1:0] shaped;
  logic                             fault_active;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      suppress_q <= pwm_ctrl_pkg::OUT_CFG_RST;
    end else if (suppress_wr_in) begin
      suppress_q <= cfg_value_in ? (suppress_q | out_sel_in)
                                 : (suppress_q & ~out_sel_in);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flip_q <= pwm_ctrl_pkg::OUT_CFG_RST;
    end else if (flip_wr_in) begin
      flip_q <= cfg_value_in ? (flip_q | out_sel_in)
                             : (flip_q & ~out_sel_in);
    end
  end

  assign fault_active = |fault_in;

  // Even outputs follow comparator A, odd ones comparator B
  for (genvar n = 0; n < pwm_ctrl_pkg::NUM_OUT; n++) begin : g_out
    assign wave[n] = (n % 2 == 0) ? wave_a[n/2] : wave_b[n/2];
  end

  // Suppression forces the inactive level before the flip, so the pin
  // still rests at the level the polarity choice defines
  assign shaped = wave &
                  ~(suppress_q & {pwm_ctrl_pkg::NUM_OUT{fault_active}});

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pwm_out                  <= '0;
      suppress_on_fault_out    <= pwm_ctrl_pkg::OUT_CFG_RST;
      output_polarity_flip_out <= pwm_ctrl_pkg::OUT_CFG_RST;
    end else begin
      pwm_out                  <= shaped ^ flip_q;
      suppress_on_fault_out    <= suppress_q;
      output_polarity_flip_out <= flip_q;
    end
  end

endmodule

// file: core/pwm_ctrl_pkg.sv
// Shared constants and types for the PWM event, fault and output control
package pwm_ctrl_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NUM_GEN     = 4;
  localparam int NUM_OUT     = 8;
  localparam int NUM_FAULT   = 4;
  localparam int NUM_EV      = 6;
  localparam int PERIOD_W    = 16;

  // ----------------------------------------------------------------------
  // Event bit positions, shared by interrupt and trigger enables
  // ----------------------------------------------------------------------
  localparam int EV_ZERO     = 0;
  localparam int EV_LOAD     = 1;
  localparam int EV_A_UP     = 2;
  localparam int EV_A_DN     = 3;
  localparam int EV_B_UP     = 4;
  localparam int EV_B_DN     = 5;

  // Interrupt enables in the low six bits, trigger enables above them
  localparam int IT_W        = 12;
  localparam int IRQ_LSB     = 0;
  localparam int TRIG_LSB    = 6;

  // Module status layout: generator summaries low, faults high
  localparam int MOD_W       = 8;
  localparam int MOD_GEN_LSB = 0;
  localparam int MOD_FLT_LSB = 4;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [IT_W-1:0]    IT_EN_RST   = 12'h000;
  localparam logic [MOD_W-1:0]   MOD_EN_RST  = 8'h00;
  localparam logic [NUM_OUT-1:0] OUT_CFG_RST = 8'h00;
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 16'h0000;
  localparam logic [PERIOD_W-1:0] CMP_RST    = 16'h0000;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic cmp_b_falling;
    logic cmp_b_rising;
    logic cmp_a_falling;
    logic cmp_a_rising;
    logic counter_load;
    logic counter_zero;
  } gen_events_t;

  typedef enum logic {
    DIR_DOWN = 1'b0,
    DIR_UP   = 1'b1
  } count_dir_t;

endpackage

// file: core/pwm_gen_unit.sv
// One PWM generator: counter, deferred period and compare update, events
`timescale 1ns/1ns
module pwm_gen_unit #(
  parameter int W = 16
) (
  input  wire logic                      clk_sys_in,
  input  wire logic                      rst_b_in,
  input  wire logic                      run_in,
  input  wire logic                      up_down_in,
  input  wire logic                      period_wr_in,
  input  wire logic [W-1:0]              period_in,
  input  wire logic                      cmp_a_wr_in,
  input  wire logic [W-1:0]              cmp_a_in,
  input  wire logic                      cmp_b_wr_in,
  input  wire logic [W-1:0]              cmp_b_in,
  output logic      [W-1:0]              period_prog_out,
  output pwm_ctrl_pkg::gen_events_t      events_out,
  output logic                           wave_a_out,
  output logic                           wave_b_out
);

  localparam logic [W-1:0] ONE  = {{(W-1){1'b0}}, 1'b1};
  localparam logic [W-1:0] ZERO = {W{1'b0}};

  logic [W-1:0]             period_pend_q;
  logic [W-1:0]             period_act_q;
  logic [W-1:0]             cmp_a_pend_q;
  logic [W-1:0]             cmp_a_act_q;
  logic [W-1:0]             cmp_b_pend_q;
  logic [W-1:0]             cmp_b_act_q;
  logic                     upd_pend_q;
  logic [W-1:0]             cnt_q;
  pwm_ctrl_pkg::count_dir_t dir_q;
  logic                     at_zero;
  logic                     apply;
  logic [W-1:0]             top;
  logic [W-1:0]             top_next;
  logic [W-1:0]             period_next;

  assign at_zero = (cnt_q == ZERO);
  // Updates land only at zero so no pulse comes out short or long
  assign apply   = at_zero && upd_pend_q;
  assign period_next = apply ? period_pend_q : period_act_q;
  // Zero pulses come one period apart; an odd period in up-down mode gives one tick less
  assign top      = up_down_in ? (period_act_q >> 1) :
                    (period_act_q == ZERO ? ZERO : period_act_q - ONE);
  assign top_next = up_down_in ? (period_next >> 1) :
                    (period_next == ZERO ? ZERO : period_next - ONE);

  // ----------------------------------------------------------------------
  // Programmed values and deferred update
  // ----------------------------------------------------------------------
  // The readback is the last write, not the active period
  assign period_prog_out = period_pend_q;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      period_pend_q <= pwm_ctrl_pkg::PERIOD_RST;
      cmp_a_pend_q  <= pwm_ctrl_pkg::CMP_RST;
      cmp_b_pend_q  <= pwm_ctrl_pkg::CMP_RST;
    end else begin
      // A later write simply overwrites what is still pending
      if (period_wr_in) begin
        period_pend_q <= period_in;
      end
      if (cmp_a_wr_in) begin
        cmp_a_pend_q <= cmp_a_in;
      end
      if (cmp_b_wr_in) begin
        cmp_b_pend_q <= cmp_b_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      period_act_q <= pwm_ctrl_pkg::PERIOD_RST;
      cmp_a_act_q  <= pwm_ctrl_pkg::CMP_RST;
      cmp_b_act_q  <= pwm_ctrl_pkg::CMP_RST;
    end else if (apply) begin
      period_act_q <= period_pend_q;
      cmp_a_act_q  <= cmp_a_pend_q;
      cmp_b_act_q  <= cmp_b_pend_q;
    end
  end

  // A write in the applying cycle stays pending for the next zero
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      upd_pend_q <= 1'b0;
    end else if (period_wr_in || cmp_a_wr_in || cmp_b_wr_in) begin
      upd_pend_q <= 1'b1;
    end else if (apply) begin
      upd_pend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= ZERO;
      dir_q <= pwm_ctrl_pkg::DIR_DOWN;
    end else if (run_in) begin
      if (!up_down_in) begin
        dir_q <= pwm_ctrl_pkg::DIR_DOWN;
        cnt_q <= at_zero ? top_next : cnt_q - ONE;
      end else if (at_zero) begin
        dir_q <= pwm_ctrl_pkg::DIR_UP;
        cnt_q <= (top_next == ZERO) ? ZERO : ONE;
      end else if (dir_q == pwm_ctrl_pkg::DIR_UP && cnt_q < top) begin
        cnt_q <= cnt_q + ONE;
      end else begin
        dir_q <= pwm_ctrl_pkg::DIR_DOWN;
        cnt_q <= cnt_q - ONE;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Events and waveforms, registered
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      events_out <= '0;
      wave_a_out <= 1'b0;
      wave_b_out <= 1'b0;
    end else begin
      events_out.counter_zero  <= run_in && at_zero;
      events_out.counter_load  <= run_in && (cnt_q == top);
      events_out.cmp_a_rising  <= run_in && (cnt_q == cmp_a_act_q) &&
                                  (dir_q == pwm_ctrl_pkg::DIR_UP);
      events_out.cmp_a_falling <= run_in && (cnt_q == cmp_a_act_q) &&
                                  (dir_q == pwm_ctrl_pkg::DIR_DOWN);
      events_out.cmp_b_rising  <= run_in && (cnt_q == cmp_b_act_q) &&
                                  (dir_q == pwm_ctrl_pkg::DIR_UP);
      events_out.cmp_b_falling <= run_in && (cnt_q == cmp_b_act_q) &&
                                  (dir_q == pwm_ctrl_pkg::DIR_DOWN);
      wave_a_out <= run_in && (cnt_q < cmp_a_act_q);
      wave_b_out <= run_in && (cnt_q < cmp_b_act_q);
    end
  end

endmodule

// file: dv/pwm_ctrl_props.sv
// Assertion checker for the PWM event, fault and output control ports
`timescale 1ns/1ns
module pwm_ctrl_props #(
  parameter int G = pwm_ctrl_pkg::NUM_GEN,
  parameter int W = pwm_ctrl_pkg::PERIOD_W
) (
  input logic                clk_sys_in,
  input logic                rst_b_in,
  input logic [G-1:0]        period_wr_in,
  input logic [W-1:0]        period_wdata_in,
  input logic [G-1:0][W-1:0] period_rd_out,
  input logic [G-1:0][11:0]  inttrig_set_in,
  input logic [G-1:0][11:0]  inttrig_clr_in,
  input logic [G-1:0][11:0]  inttrig_en_out,
  input logic [G-1:0][5:0]   gen_trig_out,
  input logic [7:0]          mod_en_set_in,
  input logic [7:0]          mod_en_clr_in,
  input logic [7:0]          mod_en_out,
  input logic                select_masked_view_in,
  input logic [7:0]          mod_status_out,
  input logic [3:0]          fault_in,
  input logic [7:0]          suppress_on_fault_out,
  input logic [7:0]          output_polarity_flip_out,
  input logic [7:0]          pwm_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Trigger enables one cycle back, since the pulse is registered
  logic [G-1:0][5:0] trig_en_q;
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      trig_en_q <= '0;
    end else begin
      for (int g = 0; g < G; g++) begin
        trig_en_q[g] <= inttrig_en_out[g][pwm_ctrl_pkg::TRIG_LSB +: 6];
      end
    end
  end
  sequence s_single_wr;
    period_wr_in[0] ##1 !period_wr_in[0];
  endsequence
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  a_reset_all_zero: assert property ($rose(rst_b_in) |->
    inttrig_en_out == '0 && mod_en_out == '0 &&
    suppress_on_fault_out == '0 && output_polarity_flip_out == '0)
    else $error("enables not zero after reset");
  a_gen_en_set: assert property (inttrig_set_in != '0 |=>
    (inttrig_en_out & $past(inttrig_set_in)) == $past(inttrig_set_in))
    else $error("generator enable set lost");
  a_gen_en_clear: assert property (inttrig_clr_in != '0 |=>
    (inttrig_en_out & $past(inttrig_clr_in) & ~$past(inttrig_set_in)) == '0)
    else $error("generator enable clear lost");
  a_gen_en_keep: assert property (1'b1 |=>
    ((inttrig_en_out ^ $past(inttrig_en_out)) & ~$past(inttrig_set_in)
     & ~$past(inttrig_clr_in)) == '0)
    else $error("untouched generator enable changed");
  a_trig_needs_en: assert property ((gen_trig_out & ~trig_en_q) == '0)
    else $error("trigger pulse without enable");
  a_mod_en_set: assert property (mod_en_set_in != '0 |-> ##2
    (mod_en_out & $past(mod_en_set_in, 2)) == $past(mod_en_set_in, 2))
    else $error("module enable set lost");
  a_mod_en_clear: assert property (mod_en_clr_in != '0 |-> ##2
    (mod_en_out & $past(mod_en_clr_in, 2) & ~$past(mod_en_set_in, 2)) == '0)
    else $error("module enable clear lost");
  a_masked_view_and: assert property ($past(select_masked_view_in) &&
    select_masked_view_in && $stable(mod_en_out) &&
    $past(mod_en_set_in) == '0 && $past(mod_en_clr_in) == '0 |->
    (mod_status_out & ~mod_en_out) == '0)
    else $error("masked status outside enables");
  a_fault_suppress: assert property (fault_in != '0 &&
    $past(fault_in) != '0 && $past(fault_in, 2) != '0 &&
    $stable(suppress_on_fault_out) && $stable(output_polarity_flip_out) |->
    ((pwm_out ^ output_polarity_flip_out) & suppress_on_fault_out) == '0)
    else $error("suppressed output active during fault");
  a_period_readback: assert property (s_single_wr |=>
    period_rd_out[0] == $past(period_wdata_in, 2))
    else $error("period readback not last write");
endmodule
bind pwm_event_fault_output_ctrl pwm_ctrl_props #(.G(G), .W(W))
  i_pwm_ctrl_props (.*);

// file: dv/pwm_event_fault_output_ctrl_test.sv
// Self-checking bench for the PWM event, fault and output control
`timescale 1ns/1ns
module pwm_event_fault_output_ctrl_test;
  localparam int G = pwm_ctrl_pkg::NUM_GEN;
  localparam int W = pwm_ctrl_pkg::PERIOD_W;
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [G-1:0] gen_run_in, gen_up_down_in, period_wr_in, cmp_a_wr_in;
  logic [G-1:0] cmp_b_wr_in;
  logic [W-1:0] period_wdata_in, cmp_wdata_in;
  logic [G-1:0][W-1:0] period_rd_out;
  logic [G-1:0][11:0] inttrig_set_in, inttrig_clr_in, inttrig_en_out;
  logic [G-1:0][5:0] gen_status_clr_in, gen_status_out, gen_trig_out;
  logic [7:0] mod_en_set_in, mod_en_clr_in, mod_en_out, mod_status_out;
  logic [3:0] fault_irq_clr_in, fault_in;
  logic select_masked_view_in, suppress_wr_in, flip_wr_in, cfg_value_in;
  logic [7:0] out_sel_in, suppress_on_fault_out, output_polarity_flip_out;
  logic [7:0] pwm_out;
  int mismatches = 0;
  int tests_run = 0;
  int cyc_cnt = 0;
  pwm_event_fault_output_ctrl i_pwm_event_fault_output_ctrl (.*);
  always #20 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) cyc_cnt++;
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Bounded wait for a zero trigger pulse of generator 0
  task automatic wait_zero(output int t);
    int n;
    n = 0;
    while (gen_trig_out[0][pwm_ctrl_pkg::EV_ZERO] !== 1'b1) begin
      cyc(1);
      n++;
      if (n > 300) begin
        chk("zero pulse wait", 16'h1, 16'h0);
        stop_test();
      end
    end
    t = cyc_cnt;
    cyc(1);
  endtask
  task automatic out_cfg(input logic f, v, input logic [7:0] sel);
    {out_sel_in, cfg_value_in, flip_wr_in, suppress_wr_in} = {sel, v, f, !f};
    cyc(1);
    {flip_wr_in, suppress_wr_in} = 2'b00;
    cyc(5);
  endtask
  task automatic st_clr(input logic [5:0] m);
    gen_status_clr_in[0] = m;
    cyc(1);
    gen_status_clr_in[0] = 6'h00;
    cyc(2);
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_enables();
    for (int g = 0; g < G; g++) begin
      for (int b = 0; b < 12; b++) begin
        inttrig_set_in[g][b] = 1'b1;
        cyc(1);
        inttrig_set_in[g][b] = 1'b0;
        chk("it set", 16'h0fff >> (11 - b), 16'(inttrig_en_out[g]));
      end
      for (int b = 0; b < 12; b++) begin
        inttrig_clr_in[g][b] = 1'b1;
        cyc(1);
        inttrig_clr_in[g][b] = 1'b0;
        chk("it clr", {4'h0, 12'hffe << b}, 16'(inttrig_en_out[g]));
      end
    end
    // Set and clear together: set wins, and leave the zero trigger on
    inttrig_set_in[0][6] = 1'b1;
    inttrig_clr_in[0][6] = 1'b1;
    cyc(1);
    {inttrig_set_in, inttrig_clr_in} = '0;
    chk("it both", 16'h0040, {4'h0, inttrig_en_out[0]});
  endtask
  task automatic t_period();
    int t1, t2;
    period_wdata_in = 16'h0004;
    period_wr_in[0] = 1'b1;
    cyc(1);
    period_wr_in[0] = 1'b0;
    gen_run_in[0] = 1'b1;
    wait_zero(t1);
    wait_zero(t2);
    chk("spacing 4", 16'h0004, 16'(t2 - t1));
    // Back to back writes: the first goes active at the next zero, the last one at the zero after
    period_wdata_in = 16'h001e;
    period_wr_in[0] = 1'b1;
    cyc(1);
    period_wdata_in = 16'h0014;
    cyc(1);
    period_wr_in[0] = 1'b0;
    cyc(2);
    chk("period rd", 16'h0014, period_rd_out[0]);
    wait_zero(t1);
    wait_zero(t1);
    wait_zero(t2);
    chk("spacing 20", 16'h0014, 16'(t2 - t1));
    cyc(2);
    chk("st raw", 16'h1, {15'h0, gen_status_out[0][0]});
    st_clr(6'h3e);
    chk("st zero wr", 16'h1, {15'h0, gen_status_out[0][0]});
    st_clr(6'h01);
    chk("st one wr", 16'h0, {15'h0, gen_status_out[0][0]});
  endtask
  task automatic t_module();
    int t;
    for (int b = 0; b < 8; b++) begin
      mod_en_set_in[b] = 1'b1;
      cyc(1);
      mod_en_set_in[b] = 1'b0;
      cyc(1);
      chk("mod set", 16'h00ff >> (7 - b), {8'h0, mod_en_out});
    end
    for (int b = 0; b < 8; b++) begin
      mod_en_clr_in[b] = 1'b1;
      cyc(1);
      mod_en_clr_in[b] = 1'b0;
      cyc(1);
      chk("mod clr", (16'h00fe << b) & 16'h00ff, {8'h0, mod_en_out});
    end
    fault_in[1] = 1'b1;
    cyc(1);
    fault_in[1] = 1'b0;
    cyc(3);
    chk("fault raw", 16'h0020, {8'h0, mod_status_out & 8'hf0});
    select_masked_view_in = 1'b1;
    cyc(2);
    chk("fault masked", 16'h0000, {8'h0, mod_status_out});
    {inttrig_set_in[0][0], mod_en_set_in} = {1'b1, 8'h21};
    cyc(1);
    {inttrig_set_in[0][0], mod_en_set_in} = '0;
    wait_zero(t);
    cyc(3);
    chk("mod masked", 16'h0021, {8'h0, mod_status_out});
    {mod_en_clr_in[0], fault_irq_clr_in[1]} = 2'b11;
    cyc(1);
    {mod_en_clr_in[0], fault_irq_clr_in[1]} = 2'b00;
    cyc(3);
    chk("mod cleared", 16'h0000, {8'h0, mod_status_out});
    select_masked_view_in = 1'b0;
  endtask
  task automatic t_outputs();
    period_wr_in = 4'b1100;
    period_wdata_in = 16'h000a;
    cmp_a_wr_in = 4'b1100;
    cmp_wdata_in = 16'hffff;
    cyc(1);
    {period_wr_in, cmp_a_wr_in, cmp_b_wr_in} = {8'h00, 4'b1100};
    cmp_wdata_in = 16'h0000;
    cyc(1);
    cmp_b_wr_in = '0;
    gen_run_in[3:2] = 2'b11;
    cyc(6);
    chk("plain", 16'h0005, {12'h0, pwm_out[7:4]});
    out_cfg(1'b1, 1'b1, 8'h30);
    chk("flip", 16'h0006, {12'h0, pwm_out[7:4]});
    out_cfg(1'b1, 1'b0, 8'h30);
    fault_in[0] = 1'b1;
    out_cfg(1'b0, 1'b1, 8'h40);
    chk("suppress", 16'h0001, {12'h0, pwm_out[7:4]});
    out_cfg(1'b1, 1'b1, 8'h40);
    chk("supp flip", 16'h0005, {12'h0, pwm_out[7:4]});
    fault_in[0] = 1'b0;
  endtask
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {gen_run_in, gen_up_down_in, period_wr_in, cmp_a_wr_in, cmp_b_wr_in,
     period_wdata_in, cmp_wdata_in, inttrig_set_in, inttrig_clr_in,
     gen_status_clr_in, mod_en_set_in, mod_en_clr_in, fault_irq_clr_in,
     fault_in, select_masked_view_in, suppress_wr_in, flip_wr_in,
     out_sel_in, cfg_value_in} = '0;
    cyc(4);
    rst_b_in = 1'b1;
    cyc(1);
    chk("rst it", 16'h0, {15'h0, |inttrig_en_out});
    chk("rst supp", 16'h0, 16'(suppress_on_fault_out));
    chk("rst flip", 16'h0, 16'(output_polarity_flip_out));
    t_enables();
    t_period();
    t_module();
    t_outputs();
    stop_test();
  end
endmodule
